// ---- fisf_defines.svh ----
// Register offsets, bit positions and sizes for the FSK flag register bank.
// Included by the flag bank and the testbench; definitions only.
`ifndef FISF_DEFINES_SVH
`define FISF_DEFINES_SVH

// --------------------------------------------------------------------------
// Register indices and byte addresses
// --------------------------------------------------------------------------
`define FISF_IDX_FLAGS1    8'h3e
`define FISF_IDX_FLAGS2    8'h3f
`define FISF_IDX_CTRL      8'h40
`define FISF_ADDR_FLAGS1   12'h0f8
`define FISF_ADDR_FLAGS2   12'h0fc
`define FISF_ADDR_CTRL     12'h100

// --------------------------------------------------------------------------
// First flag register bits
// --------------------------------------------------------------------------
`define FISF_B1_STATE_OK   7
`define FISF_B1_RX_SET     6
`define FISF_B1_TX_SET     5
`define FISF_B1_LOCK       4
`define FISF_B1_LEVEL      3
`define FISF_B1_TIMEOUT    2
`define FISF_B1_PREAMBLE   1
`define FISF_B1_SYNC       0

// --------------------------------------------------------------------------
// Second flag register bits
// --------------------------------------------------------------------------
`define FISF_B2_FULL       7
`define FISF_B2_EMPTY      6
`define FISF_B2_THRESH     5
`define FISF_B2_OVERFLOW   4
`define FISF_B2_SENT       3
`define FISF_B2_RECEIVED   2
`define FISF_B2_CRC_OK     1
`define FISF_B2_SUPPLY     0

// --------------------------------------------------------------------------
// Control register fields and sizes
// --------------------------------------------------------------------------
`define FISF_C_MON_EN      3
`define FISF_C_CONT_MODE   4
`define FISF_C_CRC_EN      5
`define FISF_C_KEEP        6
`define FISF_CTRL_RESET    8'h00
`define FISF_CTRL_WMASK    8'h78
`define FISF_QUEUE_BYTES   7'h42
`define FISF_QUEUE_THR_DEF 7'h0f

`endif

// ---- fisf_pkg.sv ----
// Types shared by the FSK flag register bank.
// Assumes fisf_defines.svh sits in the same folder.
package fisf_pkg;

  // ------------------------------------------------------------------------
  // Operating states of the modem
  // ------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FISF_SLEEP,
    FISF_STANDBY,
    FISF_SYNTH,
    FISF_TX,
    FISF_RX
  } fisf_mode_e;

  // ------------------------------------------------------------------------
  // Events and conditions reported by the modem datapath
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic state_reached;   // Requested state is ready
    logic rx_settled;      // RSSI, AGC and AFC done
    logic tx_settled;      // PA ramp-up done
    logic pll_locked;      // Synthesizer lock level
    logic level_above;     // Signal level above limit
    logic timeout;         // Receive timeout event
    logic preamble;        // Preamble found event
    logic sync_hit;        // Sync word and address event
    logic overrun;         // Queue overrun event
    logic frame_sent;      // Whole packet sent event
    logic last_byte;       // Last payload byte received
    logic crc_good;        // Payload check result valid
    logic supply_low;      // Supply below threshold level
  } fisf_events_s;

endpackage

// ---- fisf_flag_bank.sv ----
// Interrupt and status flag registers of the FSK/OOK modem, on APB.
// Assumes the modem datapath supplies mode, events and the queue count,
// all synchronous to I_CLK.
`include "fisf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fisf_flag_bank #(
  parameter int                ADDR_W    = 12,
  parameter logic [6:0]        QUEUE_MAX = `FISF_QUEUE_BYTES
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RESET_N,
  input  wire logic                 I_PSEL,
  input  wire logic                 I_PENABLE,
  input  wire logic                 I_PWRITE,
  input  wire logic [ADDR_W-1:0]    I_PADDR,
  input  wire logic [31:0]          I_PWDATA,
  input  wire logic [3:0]           I_PSTRB,
  input  wire fisf_pkg::fisf_mode_e I_MODE,
  input  wire fisf_pkg::fisf_events_s I_EVENTS,
  input  wire logic [6:0]           I_QUEUE_COUNT,
  input  wire logic [6:0]           I_QUEUE_THRESHOLD,
  output logic [31:0]               O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  output logic                      O_QUEUE_FLUSH,
  output logic                      O_SUPPLY_MON_EN
);

  // ------------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------------
  logic [7:0] flags1_reg;
  logic [7:0] flags1_next;
  logic [7:0] flags2_reg;
  logic [7:0] flags2_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  fisf_pkg::fisf_mode_e mode_reg;

  // Access phase; the slave answers in the second access cycle
  wire access   = I_PSEL & I_PENABLE;
  wire hit_f1   = (I_PADDR == ADDR_W'(`FISF_ADDR_FLAGS1));
  wire hit_f2   = (I_PADDR == ADDR_W'(`FISF_ADDR_FLAGS2));
  wire hit_ctl  = (I_PADDR == ADDR_W'(`FISF_ADDR_CTRL));
  wire mapped   = hit_f1 | hit_f2 | hit_ctl;
  wire wr_ok    = access & I_PWRITE & I_PSTRB[0] & ~O_PREADY;
  wire wr_f1    = wr_ok & hit_f1;
  wire wr_f2    = wr_ok & hit_f2;
  wire wr_ctl   = wr_ok & hit_ctl;
  wire [7:0] wd = I_PWDATA[7:0];

  // ------------------------------------------------------------------------
  // Modem condition decode
  // ------------------------------------------------------------------------
  wire in_rx     = (I_MODE == fisf_pkg::FISF_RX);
  wire in_tx     = (I_MODE == fisf_pkg::FISF_TX);
  wire in_sleep  = (I_MODE == fisf_pkg::FISF_SLEEP);
  wire active    = (I_MODE == fisf_pkg::FISF_SYNTH) | in_rx | in_tx;
  wire mode_chg  = (I_MODE != mode_reg);
  wire q_empty   = (I_QUEUE_COUNT == 7'h00);
  wire cont_mode = ctrl_reg[`FISF_C_CONT_MODE];
  wire crc_en    = ctrl_reg[`FISF_C_CRC_EN];
  wire crc_keep  = ctrl_reg[`FISF_C_KEEP];
  wire mon_en    = ctrl_reg[`FISF_C_MON_EN];
  wire crc_gate  = ~crc_en | crc_keep | I_EVENTS.crc_good;

  // Write-one-clear strobes; a zero bit leaves its flag alone
  // zero writes ignored
  wire clr_level = wr_f1 & wd[`FISF_B1_LEVEL];
  wire clr_pre   = wr_f1 & wd[`FISF_B1_PREAMBLE];
  wire clr_sync  = wr_f1 & wd[`FISF_B1_SYNC] & cont_mode;
  wire clr_ovf   = wr_f2 & wd[`FISF_B2_OVERFLOW];
  wire clr_sup   = wr_f2 & wd[`FISF_B2_SUPPLY];

  // ------------------------------------------------------------------------
  // First flag register next value; set wins over clear
  // ------------------------------------------------------------------------
  always_comb begin
    flags1_next = flags1_reg;
    flags1_next[`FISF_B1_STATE_OK] = I_EVENTS.state_reached & ~mode_chg;
    flags1_next[`FISF_B1_RX_SET] = in_rx & I_EVENTS.rx_settled;
    flags1_next[`FISF_B1_TX_SET] = in_tx & I_EVENTS.tx_settled;
    flags1_next[`FISF_B1_LOCK] = active & I_EVENTS.pll_locked;
    if (!in_rx || clr_level) begin
      flags1_next[`FISF_B1_LEVEL] = 1'b0;
    end
    if (in_rx && I_EVENTS.level_above) begin
      flags1_next[`FISF_B1_LEVEL] = 1'b1;
    end
    if (!in_rx || q_empty) begin
      flags1_next[`FISF_B1_TIMEOUT] = 1'b0;
    end
    if (I_EVENTS.timeout) begin
      flags1_next[`FISF_B1_TIMEOUT] = 1'b1;
    end
    if (clr_pre) begin
      flags1_next[`FISF_B1_PREAMBLE] = 1'b0;
    end
    if (I_EVENTS.preamble) begin
      flags1_next[`FISF_B1_PREAMBLE] = 1'b1;
    end
    if (!in_rx || q_empty || clr_sync) begin
      flags1_next[`FISF_B1_SYNC] = 1'b0;
    end
    if (I_EVENTS.sync_hit) begin
      flags1_next[`FISF_B1_SYNC] = 1'b1;
    end
  end

  // ------------------------------------------------------------------------
  // Second flag register next value; set wins over clear
  // ------------------------------------------------------------------------
  always_comb begin
    flags2_next = flags2_reg;
    flags2_next[`FISF_B2_FULL] = (I_QUEUE_COUNT == QUEUE_MAX);
    flags2_next[`FISF_B2_EMPTY] = q_empty;
    flags2_next[`FISF_B2_THRESH] = (I_QUEUE_COUNT > I_QUEUE_THRESHOLD);
    if (clr_ovf) begin
      flags2_next[`FISF_B2_OVERFLOW] = 1'b0;
    end
    if (I_EVENTS.overrun && !in_sleep) begin
      flags2_next[`FISF_B2_OVERFLOW] = 1'b1;
    end
    if (!in_tx) begin
      flags2_next[`FISF_B2_SENT] = 1'b0;
    end
    if (in_tx && I_EVENTS.frame_sent) begin
      flags2_next[`FISF_B2_SENT] = 1'b1;
    end
    if (q_empty) begin
      flags2_next[`FISF_B2_RECEIVED] = 1'b0;
      flags2_next[`FISF_B2_CRC_OK]   = 1'b0;
    end
    if (in_rx && I_EVENTS.last_byte && crc_gate) begin
      flags2_next[`FISF_B2_RECEIVED] = 1'b1;
    end
    if (in_rx && I_EVENTS.crc_good) begin
      flags2_next[`FISF_B2_CRC_OK] = 1'b1;
    end
    if (clr_sup) begin
      flags2_next[`FISF_B2_SUPPLY] = 1'b0;
    end
    if (mon_en && I_EVENTS.supply_low) begin
      flags2_next[`FISF_B2_SUPPLY] = 1'b1;
    end
  end

  // Control register: only defined fields are writable
  assign ctrl_next = wr_ctl ? (wd & `FISF_CTRL_WMASK) : ctrl_reg;

  // ------------------------------------------------------------------------
  // Flag and control registers
  // ------------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      flags1_reg <= 8'h00;
      flags2_reg <= 8'h00;
      ctrl_reg   <= `FISF_CTRL_RESET;
      mode_reg   <= fisf_pkg::FISF_SLEEP;
    end else begin
      flags1_reg <= flags1_next;
      flags2_reg <= flags2_next;
      ctrl_reg   <= ctrl_next;
      mode_reg   <= I_MODE;
    end
  end

  // ------------------------------------------------------------------------
  // APB answer and side outputs
  // ------------------------------------------------------------------------
  wire [7:0] rd_sel = hit_f1  ? flags1_reg :
                      hit_f2  ? flags2_reg :
                      hit_ctl ? ctrl_reg   : 8'h00;

  // One-cycle ready in the second access cycle; unmapped addresses error
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PREADY        <= 1'b0;
      O_PSLVERR       <= 1'b0;
      O_PRDATA        <= 32'h0000_0000;
      O_QUEUE_FLUSH   <= 1'b0;
      O_SUPPLY_MON_EN <= 1'b0;
    end else begin
      O_PREADY  <= access & ~O_PREADY;
      O_PSLVERR <= access & ~O_PREADY & ~mapped;
      O_PRDATA  <= (access & ~I_PWRITE & ~O_PREADY) ?
                   {24'h00_0000, rd_sel} : 32'h0;
      O_QUEUE_FLUSH   <= clr_ovf;
      O_SUPPLY_MON_EN <= ctrl_next[`FISF_C_MON_EN];
    end
  end

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_ovf_write;
    clr_ovf;
  endsequence
  sequence s_flush_seen;
    O_QUEUE_FLUSH && !flags2_reg[`FISF_B2_OVERFLOW];
  endsequence

  a_state_change_clear: assert property (
    mode_chg |=> !flags1_reg[`FISF_B1_STATE_OK])
    else $error("State flag not cleared on mode change");
  a_rx_settled_leave: assert property (
    !in_rx |=> !flags1_reg[`FISF_B1_RX_SET])
    else $error("Receive settled flag outside receive");
  a_tx_settled_leave: assert property (
    !in_tx |=> !flags1_reg[`FISF_B1_TX_SET])
    else $error("Transmit settled flag outside transmit");
  a_lock_follows: assert property (
    ##1 flags1_reg[`FISF_B1_LOCK] == $past(active & I_EVENTS.pll_locked))
    else $error("Lock flag mismatch");
  a_level_set: assert property (
    in_rx && I_EVENTS.level_above |=> flags1_reg[`FISF_B1_LEVEL])
    else $error("Level flag not set");
  a_timeout_clear: assert property (
    !in_rx && !I_EVENTS.timeout |=> !flags1_reg[`FISF_B1_TIMEOUT])
    else $error("Timeout flag not cleared");
  a_preamble_sticky: assert property (
    flags1_reg[`FISF_B1_PREAMBLE] && !clr_pre
      |=> flags1_reg[`FISF_B1_PREAMBLE])
    else $error("Preamble flag lost");
  a_sync_packet_ro: assert property (
    wr_f1 && !cont_mode && in_rx && !q_empty
      && flags1_reg[`FISF_B1_SYNC] |=> flags1_reg[`FISF_B1_SYNC])
    else $error("Sync flag cleared in packet mode");
  a_full_count: assert property (
    ##1 flags2_reg[`FISF_B2_FULL] == ($past(I_QUEUE_COUNT) == QUEUE_MAX))
    else $error("Full flag mismatch");
  a_thresh_strict: assert property (
    I_QUEUE_COUNT == I_QUEUE_THRESHOLD |=> !flags2_reg[`FISF_B2_THRESH])
    else $error("Threshold flag at equal count");
  a_overflow_flush: assert property (
    (s_ovf_write and !I_EVENTS.overrun) |=> s_flush_seen)
    else $error("Overflow clear did not flush");
  a_supply_gated: assert property (
    !mon_en && !flags2_reg[`FISF_B2_SUPPLY]
      |=> !flags2_reg[`FISF_B2_SUPPLY])
    else $error("Supply flag set while disabled");
  a_apb_ready_once: assert property (
    O_PREADY |=> !O_PREADY)
    else $error("Ready held two cycles");

  // Answer timing: first access cycle, then a single ready pulse
  sequence s_access_first;
    access && !O_PREADY;
  endsequence
  sequence s_answer_pulse;
    O_PREADY ##1 !O_PREADY;
  endsequence
  a_apb_one_wait: assert property (
    s_access_first |=> s_answer_pulse)
    else $error("Ready not given after first access cycle");
  a_state_ready_set: assert property (
    I_EVENTS.state_reached && !mode_chg
      |=> flags1_reg[`FISF_B1_STATE_OK])
    else $error("State flag not set once ready");
  a_lock_absent: assert property (
    !I_EVENTS.pll_locked |=> !flags1_reg[`FISF_B1_LOCK])
    else $error("Lock flag set without lock");
  a_level_leave: assert property (
    !in_rx |=> !flags1_reg[`FISF_B1_LEVEL])
    else $error("Level flag kept outside receive");
  a_level_w1c: assert property (
    clr_level && !I_EVENTS.level_above |=> !flags1_reg[`FISF_B1_LEVEL])
    else $error("Level flag not cleared by write");
  a_timeout_empty: assert property (
    q_empty && !I_EVENTS.timeout |=> !flags1_reg[`FISF_B1_TIMEOUT])
    else $error("Timeout flag kept with empty queue");
  a_timeout_ro: assert property (
    wr_f1 && in_rx && !q_empty && flags1_reg[`FISF_B1_TIMEOUT]
      |=> flags1_reg[`FISF_B1_TIMEOUT])
    else $error("Read-only timeout flag changed by write");
  a_sync_clear: assert property (
    (!in_rx || q_empty) && !I_EVENTS.sync_hit
      |=> !flags1_reg[`FISF_B1_SYNC])
    else $error("Sync flag kept after leaving or emptying");
  a_sync_cont_w1c: assert property (
    wr_f1 && wd[`FISF_B1_SYNC] && cont_mode && !I_EVENTS.sync_hit
      |=> !flags1_reg[`FISF_B1_SYNC])
    else $error("Sync flag not cleared in continuous mode");
  a_empty_set: assert property (
    q_empty |=> flags2_reg[`FISF_B2_EMPTY])
    else $error("Empty flag missing at zero count");
  a_empty_clear: assert property (
    !q_empty |=> !flags2_reg[`FISF_B2_EMPTY])
    else $error("Empty flag set with bytes present");
  a_thresh_above: assert property (
    I_QUEUE_COUNT > I_QUEUE_THRESHOLD |=> flags2_reg[`FISF_B2_THRESH])
    else $error("Threshold flag missing above setting");
  a_overflow_set: assert property (
    I_EVENTS.overrun && !in_sleep |=> flags2_reg[`FISF_B2_OVERFLOW])
    else $error("Overflow flag not set");
  a_overflow_sleep: assert property (
    in_sleep && !flags2_reg[`FISF_B2_OVERFLOW]
      |=> !flags2_reg[`FISF_B2_OVERFLOW])
    else $error("Overflow flag set in sleep");
  a_flush_needs_w1c: assert property (
    !clr_ovf |=> !O_QUEUE_FLUSH)
    else $error("Queue flushed without overflow clear");
  a_overflow_zero_wr: assert property (
    wr_f2 && !wd[`FISF_B2_OVERFLOW] && flags2_reg[`FISF_B2_OVERFLOW]
      |=> flags2_reg[`FISF_B2_OVERFLOW])
    else $error("Overflow flag cleared by zero write");
  a_sent_set: assert property (
    in_tx && I_EVENTS.frame_sent |=> flags2_reg[`FISF_B2_SENT])
    else $error("Sent flag not set");
  a_sent_leave: assert property (
    !in_tx |=> !flags2_reg[`FISF_B2_SENT])
    else $error("Sent flag kept outside transmit");
  a_received_set: assert property (
    in_rx && I_EVENTS.last_byte && crc_gate
      |=> flags2_reg[`FISF_B2_RECEIVED])
    else $error("Received flag not set");
  a_received_crc: assert property (
    in_rx && I_EVENTS.last_byte && crc_en && !crc_keep
      && !I_EVENTS.crc_good && !flags2_reg[`FISF_B2_RECEIVED]
      |=> !flags2_reg[`FISF_B2_RECEIVED])
    else $error("Received flag set on bad check");
  a_crc_set: assert property (
    in_rx && I_EVENTS.crc_good |=> flags2_reg[`FISF_B2_CRC_OK])
    else $error("Check flag not set");
  a_crc_empty: assert property (
    q_empty && !I_EVENTS.crc_good |=> !flags2_reg[`FISF_B2_CRC_OK])
    else $error("Check flag kept with empty queue");
  a_supply_sticky: assert property (
    flags2_reg[`FISF_B2_SUPPLY] && !clr_sup |=> flags2_reg[`FISF_B2_SUPPLY])
    else $error("Supply flag lost without write");
  a_supply_set: assert property (
    mon_en && I_EVENTS.supply_low |=> flags2_reg[`FISF_B2_SUPPLY])
    else $error("Supply flag not set while enabled");
  a_slverr_unmapped: assert property (
    (s_access_first and !mapped) |=> O_PSLVERR && O_PREADY)
    else $error("Unmapped access gave no error");
  a_prdata_idle: assert property (
    !O_PREADY |-> O_PRDATA == 32'h0000_0000)
    else $error("Read data outside answer cycle");

endmodule

`default_nettype wire

// ---- tb_fsk_irq_status_flags.sv ----
// Testbench for the FSK flag register bank: APB tasks and scenarios.
// Assumes fisf_pkg and fisf_flag_bank are compiled before this file.
`include "fisf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_fsk_irq_status_flags;
  // ------------------------------------------------------------------
  // Signals and event masks
  // ------------------------------------------------------------------
  logic                 clk;
  logic                 rst_n;
  logic                 psel;
  logic                 pen;
  logic                 pwr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  fisf_pkg::fisf_mode_e mode;
  logic [12:0]          ev;
  logic [6:0]           q;
  logic [6:0]           thr;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 perr;
  logic                 flush;
  logic                 mon_en;
  int                   bad_count = 0;
  int                   n_checks = 0;
  int                   flushes = 0;
  localparam logic [12:0] e_state = 13'h1000, e_rx = 13'h0800;
  localparam logic [12:0] e_tx = 13'h0400, e_lock = 13'h0200;
  localparam logic [12:0] e_lvl = 13'h0100, e_to = 13'h0080;
  localparam logic [12:0] e_pre = 13'h0040, e_sync = 13'h0020;
  localparam logic [12:0] e_ovr = 13'h0010, e_sent = 13'h0008;
  localparam logic [12:0] e_last = 13'h0004, e_crc = 13'h0002;
  localparam logic [12:0] e_low = 13'h0001;
  localparam logic [11:0] f1 = `FISF_ADDR_FLAGS1;
  localparam logic [11:0] f2 = `FISF_ADDR_FLAGS2;
  localparam logic [11:0] cr = `FISF_ADDR_CTRL;

  fisf_flag_bank dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(pstrb), .I_MODE(mode), .I_EVENTS(ev), .I_QUEUE_COUNT(q),
    .I_QUEUE_THRESHOLD(thr), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(perr), .O_QUEUE_FLUSH(flush), .O_SUPPLY_MON_EN(mon_en));

  // ------------------------------------------------------------------
  // Clock, flush pulse counter and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (flush === 1'b1) flushes <= flushes + 1;
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    r = prdata; e = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, {24'h0, x});
  endtask
  task automatic md(input fisf_pkg::fisf_mode_e m);
    @(posedge clk) mode <= m;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge clk) ev <= ev | m;
    @(posedge clk) ev <= ev & ~m;
  endtask
  task automatic setq(input logic [6:0] c);
    @(posedge clk) q <= c;
    repeat (2) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic s_regs();
    logic [31:0] r; logic e;
    rc(f1, 8'h00); rc(f2, 8'h40); rc(cr, 8'h00);
    wr(cr, 8'hff); rc(cr, 8'h78); chk(mon_en, 1);
    pstrb <= 4'h0; wr(cr, 8'h00); pstrb <= 4'hf;
    rc(cr, 8'h78); wr(cr, 8'h00);
    apb(1'b1, 12'h104, 32'hff, r, e); chk(e, 1);
    apb(1'b0, 12'h104, 32'h0, r, e); chk({r[30:0], e}, 1);
  endtask
  task automatic s_modes();
    @(posedge clk) ev <= e_state | e_rx | e_tx | e_lock;
    md(fisf_pkg::FISF_RX); rc(f1, 8'hd0);
    md(fisf_pkg::FISF_TX); rc(f1, 8'hb0);
    md(fisf_pkg::FISF_SYNTH); rc(f1, 8'h90);
    md(fisf_pkg::FISF_STANDBY); rc(f1, 8'h80);
    @(posedge clk) ev <= 13'h0;
    md(fisf_pkg::FISF_SLEEP); rc(f1, 8'h00);
  endtask
  task automatic s_level();
    md(fisf_pkg::FISF_RX); pulse(e_lvl); rc(f1, 8'h08);
    wr(f1, 8'hf7); rc(f1, 8'h08);
    wr(f1, 8'h08); rc(f1, 8'h00);
    pulse(e_lvl); md(fisf_pkg::FISF_STANDBY); rc(f1, 8'h00);
  endtask
  task automatic s_detect();
    setq(7'd5); md(fisf_pkg::FISF_RX);
    pulse(e_to | e_pre | e_sync); rc(f1, 8'h07);
    wr(f1, 8'h07); rc(f1, 8'h05);
    wr(cr, 8'h10); wr(f1, 8'h01); rc(f1, 8'h04);
    pulse(e_sync); rc(f1, 8'h05);
    setq(7'd0); rc(f1, 8'h00);
    setq(7'd5); pulse(e_to | e_sync); md(fisf_pkg::FISF_STANDBY);
    rc(f1, 8'h00);
    pulse(e_pre); rc(f1, 8'h02);
    wr(f1, 8'h02); rc(f1, 8'h00);
    wr(cr, 8'h00); setq(7'd0);
  endtask
  task automatic s_queue();
    logic [6:0] t[8] = '{0, 1, 15, 16, 65, 66, 3, 4};
    foreach (t[i]) begin
      if (i == 6) thr <= 7'd3;
      setq(t[i]);
      rc(f2, {t[i] == 66, t[i] == 0, t[i] > thr, 5'h0});
    end
    thr <= `FISF_QUEUE_THR_DEF; setq(7'd0); rc(f2, 8'h40);
  endtask
  task automatic s_overflow();
    int n;
    md(fisf_pkg::FISF_SLEEP); setq(7'd10); pulse(e_ovr); rc(f2, 8'h00);
    md(fisf_pkg::FISF_STANDBY); pulse(e_ovr); rc(f2, 8'h10);
    wr(f2, 8'hef); rc(f2, 8'h10);
    n = flushes; wr(f2, 8'h10); repeat (2) @(posedge clk);
    chk(flushes, n + 1); rc(f2, 8'h00);
  endtask
  task automatic s_frames();
    setq(7'd5); md(fisf_pkg::FISF_TX); pulse(e_sent);
    rc(f2, 8'h08); md(fisf_pkg::FISF_STANDBY); rc(f2, 8'h00);
    md(fisf_pkg::FISF_RX); wr(cr, 8'h20);
    pulse(e_last); rc(f2, 8'h00);
    pulse(e_last | e_crc); rc(f2, 8'h06);
    setq(7'd0); rc(f2, 8'h40);
    setq(7'd5); wr(cr, 8'h60); pulse(e_last); rc(f2, 8'h04);
    setq(7'd0); rc(f2, 8'h40); wr(cr, 8'h00);
  endtask
  task automatic s_supply();
    @(posedge clk) ev <= e_low;
    repeat (2) @(posedge clk); rc(f2, 8'h40);
    wr(cr, 8'h08); rc(f2, 8'h41);
    @(posedge clk) ev <= 13'h0;
    rc(f2, 8'h41); wr(f2, 8'h01); rc(f2, 8'h40);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; mode = fisf_pkg::FISF_SLEEP; ev = '0;
    q = '0; thr = `FISF_QUEUE_THR_DEF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    s_regs(); s_modes(); s_level(); s_detect();
    s_queue(); s_overflow(); s_frames(); s_supply();
    tally_and_finish();
  end
endmodule
`default_nettype wire
